// [include/tcc_defs.svh]
// constants for the timer capture/compare block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register indices, byte address is four times the index
`define TCC_CTL_IDX 32'hFFFF_F5A0
`define TCC_COMPARE_BUFFER_A_IDX 32'hFFFF_F5A6
`define TCC_COMPARE_BUFFER_B_IDX 32'hFFFF_F5A8
`define TCC_CNT_IDX 32'hFFFF_F5AE

// reset and counter values
`define TCC_CCR_RST 16'h0000
`define TCC_CTL_RST 16'h0000
`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_TOP 16'hFFFF
`define TCC_CNT_ONE 16'h0001
`define TCC_RD_ZERO 32'h0000_0000

// byte lanes of a full 16-bit access
`define TCC_SEL_HALF 2'b11

`endif

// [include/tcc_pkg.sv]
// types for the timer capture/compare block
`default_nettype none

package tcc_pkg;

  // operating modes
  typedef enum logic [2:0] {
    TCC_MODE_INTERVAL = 3'h0,
    TCC_MODE_EVENT = 3'h1,
    TCC_MODE_EXT_TRIG = 3'h2,
    TCC_MODE_ONE_SHOT = 3'h3,
    TCC_MODE_PWM = 3'h4,
    TCC_MODE_FREE_RUN = 3'h5,
    TCC_MODE_PULSE_MEAS = 3'h6,
    TCC_MODE_SPARE = 3'h7
  } tcc_mode_t;

  // counter sequencer states, one-hot
  typedef enum logic [3:0] {
    TCC_ST_OFF = 4'h1,
    TCC_ST_ARM = 4'h2,
    TCC_ST_WAIT = 4'h4,
    TCC_ST_RUN = 4'h8
  } tcc_state_t;

  // control register layout, lsb is count enable
  typedef struct packed {
    logic [1:0] spare;
    logic software_trigger_bit;
    logic external_event_enable;
    logic edge_select_high_b;
    logic edge_select_low_b;
    logic edge_select_high;
    logic edge_select_low;
    logic out_enable_b;
    logic out_enable_a;
    logic capture_select_b;
    logic capture_select_a;
    tcc_mode_t mode;
    logic count_enable_bit;
  } tcc_ctl_t;

endpackage

`default_nettype wire

// [core/tcc_top.sv]
// timer capture/compare channels with counter read-back, wishbone slave
//
// Function
// (RL1) channel 0 writes accepted while counting
// (RL2) channel 0 match raises its interrupt
// (RL3) channel 0 match toggles enabled output
// (RL4) cycle modes clear counter on channel 0 match
// (RL5) free-run capture latches count into channel 0
// (RL6) pulse measure capture 0 latches and clears
// (RL7) channel 0 reads stay consistent during capture
// (RL8) anytime or batch write chosen by mode
// (RL9) channel 1 role follows mode and select
// (RL10) channel 1 writes accepted while counting
// (RL11) channel 1 match interrupts, toggles enabled output
// (RL12) free-run capture latches count into channel 1
// (RL13) pulse measure capture 1 latches and clears
// (RL14) channel 1 reads stay consistent during capture
// (RL15) channel 1 read/write, 16-bit, resets zero
// (RL16) software avoids access on slow clocks
// (RL17) read-back is read-only live count
// (RL18) read-back shows zero while disabled
// (RL19) triggers honoured only in trigger modes
// (RL20) software disables capture edges in event mode
// (RL21) software selects internal clock in some modes
// (RL22) channel 0 role follows mode and select
// (RL23) enable moves counter from top to zero
// (RL24) batch values load at cycle-end clear
`timescale 1ns/10ps
`default_nettype none
`include "tcc_defs.svh"

module tcc_top #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  output logic timer_out_a,
  output logic timer_out_b,
  output logic match_irq_a,
  output logic match_irq_b
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the index decode needs at least six word-address bits
  generate
    if (AW < 8) begin : g_aw_check
      $error("tcc_top: AW must be at least 8");
    end
  endgenerate

  // ****************************************
  // functions
  // ****************************************
  // word address compare against a register index
  function automatic logic reg_hit(input logic [AW-1:0] adr, input logic [31:0] idx);
    reg_hit = (adr[AW-1:2] == idx[AW-3:0]);
  endfunction

  // valid edge per select bits, low bit rising, high bit falling
  function automatic logic edge_ok(input logic hi, input logic lo,
                                   input logic prev, input logic cur);
    edge_ok = (hi & prev & ~cur) | (lo & ~prev & cur);
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  tcc_pkg::tcc_ctl_t ctl_q;
  tcc_pkg::tcc_ctl_t wctl;
  tcc_pkg::tcc_state_t st_q;
  logic [15:0] cnt_q;
  logic [15:0] ccr_a_q;
  logic [15:0] ccr_b_q;
  logic [15:0] buf_a_q;
  logic [15:0] buf_b_q;
  logic sw_trig_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic in_a_s1_q;
  logic in_a_s2_q;
  logic in_a_p_q;
  logic in_b_s1_q;
  logic in_b_s2_q;
  logic in_b_p_q;
  logic out_a_q;
  logic out_b_q;
  logic irq_a_q;
  logic irq_b_q;
  logic req;
  logic wr_ok;
  logic wr_ctl;
  logic wr_ccr_a;
  logic wr_ccr_b;
  logic is_free;
  logic is_meas;
  logic is_batch;
  logic is_cycle;
  logic is_trig;
  logic a_cap;
  logic b_cap;
  logic running;
  logic tick;
  logic trig;
  logic cap_a;
  logic cap_b;
  logic match_a;
  logic match_b;
  logic cyc_clr;
  logic start;

  // ****************************************
  // bus decode
  // ****************************************
  // a write takes effect in the cycle the ack is raised
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_ok = req & wb_we_i & (wb_sel_i[1:0] == `TCC_SEL_HALF);
  assign wr_ctl = wr_ok & reg_hit(wb_adr_i, `TCC_CTL_IDX);
  assign wr_ccr_a = wr_ok & reg_hit(wb_adr_i, `TCC_COMPARE_BUFFER_A_IDX);
  assign wr_ccr_b = wr_ok & reg_hit(wb_adr_i, `TCC_COMPARE_BUFFER_B_IDX); // RL15
  assign wctl = tcc_pkg::tcc_ctl_t'(wb_dat_i[15:0]);

  // ****************************************
  // mode decode
  // ****************************************
  // role and write discipline of the channels
  assign is_free = (ctl_q.mode == tcc_pkg::TCC_MODE_FREE_RUN);
  assign is_meas = (ctl_q.mode == tcc_pkg::TCC_MODE_PULSE_MEAS);
  assign is_batch = (ctl_q.mode == tcc_pkg::TCC_MODE_EXT_TRIG) |
                    (ctl_q.mode == tcc_pkg::TCC_MODE_PWM); // RL8
  assign is_trig = (ctl_q.mode == tcc_pkg::TCC_MODE_EXT_TRIG) |
                   (ctl_q.mode == tcc_pkg::TCC_MODE_ONE_SHOT);
  assign is_cycle = (ctl_q.mode == tcc_pkg::TCC_MODE_INTERVAL) |
                    (ctl_q.mode == tcc_pkg::TCC_MODE_EVENT) |
                    is_trig | (ctl_q.mode == tcc_pkg::TCC_MODE_PWM);
  assign a_cap = is_meas | (is_free & ctl_q.capture_select_a); // RL22
  assign b_cap = is_meas | (is_free & ctl_q.capture_select_b); // RL9

  // ****************************************
  // input synchronisers
  // ****************************************
  // two flops per pin, a third stage for edge detection
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_a_s1_q <= 1'b0;
      in_a_s2_q <= 1'b0;
      in_a_p_q <= 1'b0;
      in_b_s1_q <= 1'b0;
      in_b_s2_q <= 1'b0;
      in_b_p_q <= 1'b0;
    end else begin
      in_a_s1_q <= capture_in_a;
      in_a_s2_q <= in_a_s1_q;
      in_a_p_q <= in_a_s2_q;
      in_b_s1_q <= capture_in_b;
      in_b_s2_q <= in_b_s1_q;
      in_b_p_q <= in_b_s2_q;
    end
  end

  // ****************************************
  // count events
  // ****************************************
  // count clock is ref_clk, or rising edges of input a
  assign tick = ctl_q.external_event_enable ? (~in_a_p_q & in_a_s2_q) : 1'b1;
  assign running = (st_q == tcc_pkg::TCC_ST_RUN);
  assign start = (st_q == tcc_pkg::TCC_ST_ARM) & tick;

  // triggers only act in the two trigger modes
  assign trig = is_trig & (sw_trig_q |
                edge_ok(ctl_q.edge_select_high, ctl_q.edge_select_low,
                        in_a_p_q, in_a_s2_q)); // RL19

  // capture edges while running in a capture role
  assign cap_a = running & a_cap & edge_ok(ctl_q.edge_select_high,
                 ctl_q.edge_select_low, in_a_p_q, in_a_s2_q);
  assign cap_b = running & b_cap & edge_ok(ctl_q.edge_select_high_b,
                 ctl_q.edge_select_low_b, in_b_p_q, in_b_s2_q);

  // compare matches against the buffers
  assign match_a = running & tick & ~a_cap & (cnt_q == buf_a_q); // RL2
  assign match_b = running & tick & ~b_cap & (cnt_q == buf_b_q); // RL11
  assign cyc_clr = match_a & is_cycle; // RL4

  // ****************************************
  // control register
  // ****************************************
  // software trigger bit reads as zero and acts as a pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctl_q <= tcc_pkg::tcc_ctl_t'(`TCC_CTL_RST);
      sw_trig_q <= 1'b0;
    end else begin
      sw_trig_q <= wr_ctl & wctl.software_trigger_bit;
      if (wr_ctl) begin
        ctl_q <= wctl;
        ctl_q.software_trigger_bit <= 1'b0;
        ctl_q.spare <= 2'b00;
      end
    end
  end

  // ****************************************
  // counter sequencer
  // ****************************************
  // off holds the top value, arm waits one count clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= tcc_pkg::TCC_ST_OFF;
    end else if (!ctl_q.count_enable_bit) begin
      st_q <= tcc_pkg::TCC_ST_OFF;
    end else begin
      case (st_q)
        tcc_pkg::TCC_ST_OFF: begin
          st_q <= tcc_pkg::TCC_ST_ARM;
        end
        tcc_pkg::TCC_ST_ARM: begin
          if (tick) begin
            st_q <= is_trig ? tcc_pkg::TCC_ST_WAIT : tcc_pkg::TCC_ST_RUN;
          end
        end
        tcc_pkg::TCC_ST_WAIT: begin
          if (trig) begin
            st_q <= tcc_pkg::TCC_ST_RUN;
          end
        end
        tcc_pkg::TCC_ST_RUN: begin
          // one-shot ends its pulse at the cycle match
          if (cyc_clr && (ctl_q.mode == tcc_pkg::TCC_MODE_ONE_SHOT)) begin
            st_q <= tcc_pkg::TCC_ST_WAIT;
          end
        end
        default: begin
          st_q <= tcc_pkg::TCC_ST_OFF;
        end
      endcase
    end
  end

  // ****************************************
  // 16-bit counter
  // ****************************************
  // wraps past the top value in free-running use
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= `TCC_CNT_TOP;
    end else if (!ctl_q.count_enable_bit) begin
      cnt_q <= `TCC_CNT_TOP;
    end else if (start) begin
      cnt_q <= `TCC_CNT_ZERO; // RL23
    end else if ((st_q == tcc_pkg::TCC_ST_WAIT) && trig) begin
      cnt_q <= `TCC_CNT_ZERO;
    end else if (running && is_meas && (cap_a || cap_b)) begin
      cnt_q <= `TCC_CNT_ZERO; // RL6 RL13
    end else if (running && trig && (ctl_q.mode == tcc_pkg::TCC_MODE_EXT_TRIG)) begin
      cnt_q <= `TCC_CNT_ZERO;
    end else if (cyc_clr) begin
      cnt_q <= `TCC_CNT_ZERO; // RL4
    end else if (running && tick) begin
      cnt_q <= cnt_q + `TCC_CNT_ONE;
    end
  end

  // ****************************************
  // channel registers
  // ****************************************
  // a capture in the same cycle as a write wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ccr_a_q <= `TCC_CCR_RST;
    end else if (cap_a) begin
      ccr_a_q <= cnt_q; // RL5 RL6
    end else if (wr_ccr_a) begin
      ccr_a_q <= wb_dat_i[15:0]; // RL1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ccr_b_q <= `TCC_CCR_RST; // RL15
    end else if (cap_b) begin
      ccr_b_q <= cnt_q; // RL12 RL13
    end else if (wr_ccr_b) begin
      ccr_b_q <= wb_dat_i[15:0]; // RL10
    end
  end

  // ****************************************
  // compare buffers
  // ****************************************
  // anytime write loads at once, batch write at the cycle-end clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buf_a_q <= `TCC_CCR_RST;
    end else if (wr_ccr_a && !is_batch) begin
      buf_a_q <= wb_dat_i[15:0]; // RL24 RL8
    end else if (start || (cyc_clr && is_batch)) begin
      buf_a_q <= ccr_a_q; // RL24
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      buf_b_q <= `TCC_CCR_RST;
    end else if (wr_ccr_b && !is_batch) begin
      buf_b_q <= wb_dat_i[15:0]; // RL24 RL8
    end else if (start || (cyc_clr && is_batch)) begin
      buf_b_q <= ccr_b_q; // RL24
    end
  end

  // ****************************************
  // timer outputs and interrupt pulses
  // ****************************************
  // a disabled output sits low and does not toggle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_a_q <= 1'b0;
    end else if (!ctl_q.out_enable_a) begin
      out_a_q <= 1'b0;
    end else if (match_a ||
                 (start && (ctl_q.mode == tcc_pkg::TCC_MODE_INTERVAL))) begin
      out_a_q <= ~out_a_q; // RL3
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_b_q <= 1'b0;
    end else if (!ctl_q.out_enable_b) begin
      out_b_q <= 1'b0;
    end else if (match_b) begin
      out_b_q <= ~out_b_q; // RL11
    end
  end

  // one-cycle match request pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      irq_a_q <= match_a; // RL2
      irq_b_q <= match_b; // RL11
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // read-back hides the top value while disabled
  always_comb begin
    rd_d = `TCC_RD_ZERO;
    if (reg_hit(wb_adr_i, `TCC_CTL_IDX)) begin
      rd_d[15:0] = ctl_q;
    end else if (reg_hit(wb_adr_i, `TCC_COMPARE_BUFFER_A_IDX)) begin
      rd_d[15:0] = ccr_a_q; // RL7
    end else if (reg_hit(wb_adr_i, `TCC_COMPARE_BUFFER_B_IDX)) begin
      rd_d[15:0] = ccr_b_q; // RL14
    end else if (reg_hit(wb_adr_i, `TCC_CNT_IDX)) begin
      rd_d[15:0] = ctl_q.count_enable_bit ? cnt_q : `TCC_CNT_ZERO; // RL17 RL18
    end
  end

  // whole-word snapshot taken in one edge, so a capture never tears it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= `TCC_RD_ZERO;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= rd_d; // RL7 RL14
      end
    end
  end

  // ****************************************
  // output drive
  // ****************************************
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign timer_out_a = out_a_q;
  assign timer_out_b = out_b_q;
  assign match_irq_a = irq_a_q;
  assign match_irq_b = irq_b_q;

endmodule // tcc_top

`default_nettype wire

// [bench/tcc_top_props.sv]
// assertions on the timer capture/compare block ports
`timescale 1ns/10ps
`default_nettype none

module tcc_top_props #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  input wire logic timer_out_a,
  input wire logic timer_out_b,
  input wire logic match_irq_a,
  input wire logic match_irq_b
);
  // ************
  // helpers
  // ************
  logic take;
  logic rd_ctl;
  logic en_q;
  // request taken at this edge
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_ctl = take && !wb_we_i && wb_adr_i == AW'(8'h80);
  // shadow of the count enable bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (take && wb_we_i && wb_adr_i == AW'(8'h80) && wb_sel_i[1:0] == 2'b11) begin
      en_q <= wb_dat_i[0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ************
  // properties
  // ************
  property p_ack_next; take |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_upper_zero; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper half set");
  property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  property p_unmapped;
    (take && !wb_we_i && wb_adr_i == AW'(8'h04)) |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctl_top; rd_ctl |=> wb_dat_o[15:13] == 3'h0; endproperty
  a_ctl_top: assert property (p_ctl_top) else $error("trigger bit reads set");
  property p_cnt_off;
    (take && !wb_we_i && wb_adr_i == AW'(8'hB8) && !en_q) |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_cnt_off: assert property (p_cnt_off) else $error("readback not zero");
  property p_toggle_b; $rose(timer_out_b) |-> match_irq_b; endproperty
  a_toggle_b: assert property (p_toggle_b) else $error("out b rose without match");
  // main scenarios reached
  c_irq_a: cover property (match_irq_a);
  c_irq_b: cover property (match_irq_b && timer_out_b);
  c_cnt_off: cover property (take && !wb_we_i && wb_adr_i == AW'(8'hB8) && !en_q);
endmodule // tcc_top_props

bind tcc_top tcc_top_props #(.AW(AW)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .capture_in_a(capture_in_a), .capture_in_b(capture_in_b), .timer_out_a(timer_out_a),
  .timer_out_b(timer_out_b), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));
`default_nettype wire

// [bench/tcc_pin_model.sv]
// capture pin sources on the far side of the block
`timescale 1ns/10ps
`default_nettype none

module tcc_pin_model (
  input wire logic ref_clk,
  output var logic capture_in_a,
  output var logic capture_in_b
);
  // pins idle low between pulses
  initial begin
    capture_in_a = 1'b0;
    capture_in_b = 1'b0;
  end
  // one high pulse, edges just after the clock
  task automatic pulse(input logic on_b, input int hi);
    @(posedge ref_clk);
    if (on_b) begin
      capture_in_b <= 1'b1;
    end else begin
      capture_in_a <= 1'b1;
    end
    repeat (hi) @(posedge ref_clk);
    capture_in_a <= 1'b0;
    capture_in_b <= 1'b0;
  endtask
endmodule // tcc_pin_model
`default_nettype wire

// [bench/test_tcc_top.sv]
// self-checking bench for the timer capture/compare block
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (g), (e)); end end

module test_tcc_top;
  // ************
  // signals
  // ************
  localparam logic [7:0] A_CTL = 8'h80;
  localparam logic [7:0] A_CC0 = 8'h98;
  localparam logic [7:0] A_CC1 = 8'hA0;
  localparam logic [7:0] A_CNT = 8'hB8;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic ref_clk;
  logic rst_n;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic cap_a;
  logic cap_b;
  logic out_a;
  logic out_b;
  logic irq_a;
  logic irq_b;
  logic [31:0] rd;
  logic ob;
  int fails;
  int num_checks;
  int gap;
  time t0;

  tcc_top #(.AW(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .capture_in_a(cap_a), .capture_in_b(cap_b), .timer_out_a(out_a),
    .timer_out_b(out_b), .match_irq_a(irq_a), .match_irq_b(irq_b));
  tcc_pin_model pins (.ref_clk(ref_clk), .capture_in_a(cap_a), .capture_in_b(cap_b));

  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ************
  // tasks
  // ************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, Z, 4'hF, rd);
    `CHK(rd, e)
  endtask
  // wait for a match pulse, bounded
  task automatic wait_irq(input logic on_b);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((on_b ? irq_b : irq_a) !== 1'b1 && n < 200);
    if ((on_b ? irq_b : irq_a) !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask
  // cycles from the last mark to the next match
  task automatic wait_gap(input logic on_b);
    wait_irq(on_b);
    gap = int'(($time - t0) / 4);
    t0 = $time;
  endtask
  // count before a pin pulse against the captured value
  task automatic cap(input logic on_b, input logic [7:0] a);
    logic [31:0] c;
    bus(1'b0, A_CNT, Z, 4'hF, c);
    pins.pulse(on_b, 4);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, a, Z, 4'hF, rd);
    `CHK(rd > c && rd - c < 32'h0000_000C, 1'b1)
    rdc(a, rd);
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, adr, sel, wdat} = '0;
    fails = 0;
    num_checks = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(A_CC1, Z);
    rdc(A_CNT, Z);
    wr(A_CC1, 32'h0000_A5A5);
    bus(1'b1, A_CC1, 32'h0000_1234, 4'hC, rd);
    rdc(A_CC1, 32'h0000_A5A5);
    wr(A_CNT, 32'h0000_5555);
    rdc(A_CNT, Z);
    wr(8'h04, 32'h0000_FFFF);
    rdc(8'h04, Z);
    done("registers");
    wr(A_CC0, 32'h0000_0009);
    wr(A_CC1, 32'h0000_0003);
    wr(A_CTL, 32'h0000_00C1);
    wait_irq(1'b0);
    t0 = $time;
    wait_gap(1'b0);
    `CHK(gap, 10)
    wr(A_CC0, 32'h0000_0013);
    wait_gap(1'b0);
    `CHK(gap, 20)
    bus(1'b0, A_CNT, Z, 4'hF, rd);
    `CHK(rd < 32'h0000_0014, 1'b1)
    ob = out_a;
    wait_irq(1'b0);
    `CHK(out_a, ~ob)
    ob = out_b;
    wait_irq(1'b1);
    `CHK(out_b, ~ob)
    t0 = $time;
    wait_gap(1'b1);
    `CHK(gap, 20)
    done("interval");
    wr(A_CTL, Z);
    rdc(A_CNT, Z);
    wr(A_CC0, 32'h0000_0009);
    wr(A_CTL, 32'h0000_0009);
    wait_irq(1'b0);
    t0 = $time;
    wr(A_CC0, 32'h0000_001D);
    wait_gap(1'b0);
    `CHK(gap, 10)
    `CHK(out_a, 1'b0)
    wait_gap(1'b0);
    `CHK(gap, 30)
    done("pwm");
    wr(A_CTL, Z);
    wr(A_CC0, 32'h0000_0005);
    wr(A_CTL, 32'h0000_0007);
    rdc(A_CNT, Z);
    t0 = $time;
    wr(A_CTL, 32'h0000_2007);
    wait_gap(1'b0);
    `CHK(gap < 12, 1'b1)
    rdc(A_CNT, Z);
    wr(A_CTL, Z);
    wr(A_CTL, 32'h0000_0105);
    pins.pulse(1'b0, 4);
    wait_irq(1'b0);
    done("trigger");
    wr(A_CTL, Z);
    wr(A_CTL, 32'h0000_053B);
    bus(1'b0, A_CNT, Z, 4'hF, rd);
    `CHK(rd < 32'h0000_0010, 1'b1)
    cap(1'b0, A_CC0);
    cap(1'b1, A_CC1);
    wr(A_CTL, Z);
    wr(A_CTL, 32'h0000_050D);
    pins.pulse(1'b0, 4);
    repeat (15) @(posedge ref_clk);
    pins.pulse(1'b1, 4);
    repeat (8) @(posedge ref_clk);
    rdc(A_CC1, 32'h0000_0013);
    bus(1'b0, A_CNT, Z, 4'hF, rd);
    `CHK(rd < 32'h0000_0010, 1'b1)
    done("capture");
    // event count: edge detection off, rising edges of input a counted
    wr(A_CTL, Z);
    wr(A_CC0, 32'h0000_0002);
    wr(A_CTL, 32'h0000_1003);
    repeat (3) pins.pulse(1'b0, 4);
    rdc(A_CNT, 32'h0000_0002);
    pins.pulse(1'b0, 1);
    wait_irq(1'b0);
    rdc(A_CNT, Z);
    done("event");
    print_verdict();
  end
endmodule // test_tcc_top
`default_nettype wire
